//--- rtl/stp_consts.svh
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH

// system clock and master oscillator rates, in hertz
`define STP_CLK_HZ 25000000
`define STP_OSC_HZ 4000000
// clock cycles per master oscillator tick (rounded down, so the tick never runs slow)
`define STP_OSC_DIV (`STP_CLK_HZ / `STP_OSC_HZ)

// regulator timing, in master oscillator cycles
`define STP_T_OFF_OSC 87
`define STP_T_BLANK_OSC 6
`define STP_T_DEAD_OSC 3

// home state of the translator: 45 degrees, both phases at 70.31 percent, both positive
`define STP_HOME_POS 6'h08
`define STP_HOME_LEVEL 7'h2d

// increment per step for select codes {b,a} = 0..3 (full, half, quarter, sixteenth)
`define STP_STEP_TBL '{6'h10, 6'h08, 6'h04, 6'h01}
// fast-decay ticks of the off-time for share codes {b,a} = 0..3
`define STP_FAST_TBL '{7'h00, 7'h16, 7'h2c, 7'h57}

`endif

//--- rtl/stp_pkg.sv
package stp_pkg;
  // decay behaviour chosen per bridge at each step
  typedef enum logic {STP_DECAY_SLOW, STP_DECAY_MIXED} stp_decay_t;
  // phase of one fixed off-time regulator
  typedef enum logic {STP_PWM_DRIVE, STP_PWM_OFF} stp_pwm_state_t;
  // dac level in 1/64 of full scale, 0..64
  typedef logic [6:0] stp_level_t;
  // position in the 64-entry sine sequence
  typedef logic [5:0] stp_pos_t;
endpackage

//--- rtl/stp_phase_if.sv
`timescale 1ns/100ps
`default_nettype none
// one phase: translator set points down, gate drives back up
interface stp_phase_if;
  import stp_pkg::*;
  stp_level_t level; // dac set point
  logic positive; // winding current sense
  stp_decay_t decay; // slow or mixed
  logic [6:0] fast_ticks; // fast share of the off-time
  logic trip; // current comparator
  logic inhibit; // force all gates off
  logic sleep; // hold the regulator at its start
  logic tick; // master oscillator enable
  logic [1:0] high_gate; // [0]=a, [1]=b
  logic [1:0] low_gate; // [0]=a, [1]=b
  modport ctrl (output level, positive, decay, fast_ticks, trip, inhibit, sleep, tick,
                input high_gate, low_gate);
  modport bridge (input level, positive, decay, fast_ticks, trip, inhibit, sleep, tick,
                  output high_gate, low_gate);
endinterface
`default_nettype wire

//--- rtl/stp_osc_div.sv
`timescale 1ns/100ps
`default_nettype none
`include "stp_consts.svh"
// master oscillator as a one-cycle enable from the system clock
module stp_osc_div #(
  parameter int DIV = `STP_OSC_DIV // clock cycles per tick
) (
  input wire logic clock, // system clock
  input wire logic reset, // async, active high
  output logic tick // one-cycle enable
);
  logic [7:0] count_reg; // cycles since last tick

  // free running, so regulator timing never stops with the translator
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_reg <= 8'h00;
      tick <= 1'b0;
    end else if (count_reg == 8'(DIV - 1)) begin
      count_reg <= 8'h00;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule // stp_osc_div
`default_nettype wire

//--- rtl/stp_bridge.sv
`timescale 1ns/100ps
`default_nettype none
`include "stp_consts.svh"
// one full bridge: fixed off-time regulator with blanking and dead time
module stp_bridge (
  input wire logic clock, // system clock
  input wire logic reset, // async, active high
  stp_phase_if.bridge ph // set points in, gates out
);
  import stp_pkg::*;
  localparam logic [6:0] OFF_LAST = 7'(`STP_T_OFF_OSC - 1); // last off tick
  localparam logic [2:0] BLANK_LEN = 3'(`STP_T_BLANK_OSC); // masked ticks
  localparam logic [1:0] DEAD_LEN = 2'(`STP_T_DEAD_OSC); // crossover gap

  stp_pwm_state_t state_reg; // drive or off
  logic [6:0] off_cnt_reg; // ticks spent off
  logic [2:0] blank_cnt_reg; // ticks since outputs switched on
  logic [1:0] gap_reg [2]; // crossover gap per half bridge
  logic [1:0] high_reg; // high-side gates
  logic [1:0] low_reg; // low-side gates
  logic [1:0] want_high; // wanted high-side pattern
  logic [1:0] want_low; // wanted low-side pattern
  logic fast_now; // fast decay part of the off-time

  // drive, trip, off for 87 ticks, back to drive; comparator masked after switching
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= STP_PWM_DRIVE;
      off_cnt_reg <= 7'h00;
      blank_cnt_reg <= 3'h0;
    end else if (ph.sleep) begin // restart a fresh cycle on wake
      state_reg <= STP_PWM_DRIVE;
      off_cnt_reg <= 7'h00;
      blank_cnt_reg <= 3'h0;
    end else if (ph.tick) begin
      case (state_reg)
        STP_PWM_DRIVE: begin
          if (blank_cnt_reg != BLANK_LEN) begin
            blank_cnt_reg <= blank_cnt_reg + 3'h1;
          end else if (ph.trip) begin
            state_reg <= STP_PWM_OFF;
            off_cnt_reg <= 7'h00;
          end
        end
        STP_PWM_OFF: begin
          if (off_cnt_reg == OFF_LAST) begin
            state_reg <= STP_PWM_DRIVE;
            blank_cnt_reg <= 3'h0;
          end else begin
            off_cnt_reg <= off_cnt_reg + 7'h01;
          end
        end
        default: state_reg <= STP_PWM_DRIVE;
      endcase
    end
  end

  // wanted gates: diagonal pair on, fast reverses it, slow recirculates on the lows
  always_comb begin
    fast_now = (ph.decay == STP_DECAY_MIXED) && (off_cnt_reg < ph.fast_ticks);
    if (state_reg == STP_PWM_DRIVE) begin
      want_high = {~ph.positive, ph.positive};
      want_low = {ph.positive, ~ph.positive};
    end else if (fast_now) begin // source and sink off
      want_high = {ph.positive, ~ph.positive};
      want_low = {~ph.positive, ph.positive};
    end else begin // source off only, synchronous rectification
      want_high = 2'b00;
      want_low = 2'b11;
    end
  end

  // gate registers; a gate turns on only after its complement has been off 3 ticks
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      high_reg <= 2'b00;
      low_reg <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        gap_reg[i] <= 2'h0;
      end
    end else if (ph.inhibit) begin
      high_reg <= 2'b00;
      low_reg <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        gap_reg[i] <= DEAD_LEN;
      end
    end else if (ph.tick) begin
      for (int i = 0; i < 2; i++) begin
        if ((high_reg[i] && !want_high[i]) || (low_reg[i] && !want_low[i])) begin
          gap_reg[i] <= DEAD_LEN;
        end else if (gap_reg[i] != 2'h0) begin
          gap_reg[i] <= gap_reg[i] - 2'h1;
        end
        if (!want_high[i]) begin
          high_reg[i] <= 1'b0;
        end else if (gap_reg[i] <= 2'h1 && !low_reg[i]) begin
          high_reg[i] <= 1'b1;
        end
        if (!want_low[i]) begin
          low_reg[i] <= 1'b0;
        end else if (gap_reg[i] <= 2'h1 && !high_reg[i]) begin
          low_reg[i] <= 1'b1;
        end
      end
    end
  end

  assign ph.high_gate = high_reg;
  assign ph.low_gate = low_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_no_shoot: assert property (!(high_reg[0] && low_reg[0]) && !(high_reg[1] && low_reg[1]))
    else $error("both gates of a half bridge on");
  chk_blank_mask: assert property (state_reg == STP_PWM_DRIVE && ph.tick && !ph.sleep &&
    blank_cnt_reg != BLANK_LEN |=> state_reg == STP_PWM_DRIVE)
    else $error("trip accepted inside blanking");
  chk_off_hold: assert property (state_reg == STP_PWM_OFF && !ph.sleep && off_cnt_reg != OFF_LAST
    |=> state_reg == STP_PWM_OFF)
    else $error("off-time ended early");
  cov_off_cycle: cover property (state_reg == STP_PWM_OFF && off_cnt_reg == OFF_LAST && ph.tick);
endmodule // stp_bridge
`default_nettype wire

//--- rtl/stp_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "stp_consts.svh"
// Behaviour
// - each step rising edge advances one increment
// - full, half, quarter and sixteenth resolutions
// - microstep selects sampled only at step edge
// - rotation sense low clockwise, high counterclockwise
// - rotation change applies at next step edge
// - reset loads home and mixed decay
// - step moves both dacs along sine sequence
// - rising or equal level gives slow decay
// - falling level takes decay from share selects
// - two independent fixed off-time regulators
// - trip ends drive: source off, or both
// - bridge stays off 87 oscillator cycles
// - comparator ignored 6 cycles after switching
// - three cycle gap between complementary gates
// - gate output high means transistor on
// - disable input high forces gates off
// - translator keeps running while gates disabled
// - sleep input low disables, release starts home
// - short sleep pulse returns to home
// - gate supply undervoltage forces gates off
module stp_top
  import stp_pkg::*;
#(
  parameter logic [5:0] STEP_TBL [0:3] = `STP_STEP_TBL, // increment per select code
  parameter logic [6:0] FAST_TBL [0:3] = `STP_FAST_TBL, // fast ticks per share code
  parameter int OSC_DIV = `STP_OSC_DIV // clocks per oscillator tick
) (
  input wire logic clock, // 25 MHz system clock
  input wire logic reset, // async, active high
  input wire logic sleep_n, // low: sleep and home
  input wire logic step_in, // rising edge steps
  input wire logic dir_ccw, // rotation sense
  input wire logic microstep_select_a, // resolution select a
  input wire logic microstep_select_b, // resolution select b
  input wire logic fast_decay_share_sel_a, // fast share select a
  input wire logic fast_decay_share_sel_b, // fast share select b
  input wire logic outputs_disable, // high: all gates off
  input wire logic gate_supply_rail_low, // undervoltage flag
  input wire logic trip_1, // phase 1 comparator
  input wire logic trip_2, // phase 2 comparator
  output logic [3:0] high_side_gate_out, // 1a,1b,2a,2b
  output logic [3:0] low_side_gate_out, // 1a,1b,2a,2b
  output stp_pkg::stp_level_t phase1_dac_level, // phase 1 set point
  output stp_pkg::stp_level_t phase2_dac_level, // phase 2 set point
  output logic phase1_positive, // phase 1 polarity
  output logic phase2_positive, // phase 2 polarity
  output stp_pkg::stp_decay_t phase1_decay, // phase 1 decay
  output stp_pkg::stp_decay_t phase2_decay, // phase 2 decay
  output logic [1:0] resolution_latched // select code in use
);
  import stp_pkg::*;

  // quarter-wave magnitude, in 1/64 of full scale, of a sequence position
  // peak holds at 15 and 16
  function automatic stp_level_t sine_level(input stp_pos_t pos);
    logic [4:0] k;
    logic [4:0] idx;

    k = pos[4:0];
    idx = (k <= 5'h10) ? k : 5'(6'h20 - {1'b0, k});
    case (idx)
      5'h00: sine_level = 7'h00;
      5'h01: sine_level = 7'h06;
      5'h02: sine_level = 7'h0c;
      5'h03: sine_level = 7'h13;
      5'h04: sine_level = 7'h18;
      5'h05: sine_level = 7'h1e;
      5'h06: sine_level = 7'h24;
      5'h07: sine_level = 7'h29;
      5'h08: sine_level = 7'h2d;
      5'h09: sine_level = 7'h31;
      5'h0a: sine_level = 7'h35;
      5'h0b: sine_level = 7'h38;
      5'h0c: sine_level = 7'h3b;
      5'h0d: sine_level = 7'h3d;
      5'h0e: sine_level = 7'h3f;
      default: sine_level = 7'h40; // 15 and 16 are both full scale
    endcase
  endfunction

  // positive current in the first half of the electrical turn
  // 0 and 32 are zero level
  function automatic logic sine_positive(input stp_pos_t pos);
    sine_positive = !pos[5];
  endfunction

  // bridge links
  stp_phase_if ph1 (); // phase 1 link
  stp_phase_if ph2 (); // phase 2 link

  // tick and step edge
  logic osc_tick; // master oscillator enable
  logic step_prev_reg; // step level of last cycle
  logic step_rise; // accepted step edge

  // position
  stp_pos_t pos_reg; // sequence position
  stp_pos_t pos_next; // position after this step
  stp_pos_t pos2_next; // phase 2 reads a quarter turn ahead
  logic [5:0] step_size; // increment for the sampled select
  logic [1:0] res_sel; // select code on the pins now

  // set points
  stp_level_t level1_reg; // phase 1 set point
  stp_level_t level2_reg; // phase 2 set point
  stp_level_t level1_next; // phase 1 next set point
  stp_level_t level2_next; // phase 2 next set point
  logic pos1_reg; // phase 1 polarity
  logic pos2_reg; // phase 2 polarity

  // decay
  stp_decay_t decay1_reg; // phase 1 decay mode
  stp_decay_t decay2_reg; // phase 2 decay mode
  stp_decay_t falling_decay; // mode for a falling level

  // latched selects
  logic [1:0] res_reg; // select code latched at last step
  logic [1:0] share_sel; // fast share code on the pins
  logic [1:0] share_reg; // share code latched at last step

  // force-off
  logic gates_off; // any reason to force gates off

  // master oscillator divider shared by both bridges
  // one tick keeps them in step
  stp_osc_div #(
    .DIV(OSC_DIV)
  ) u_osc (
    .clock(clock),
    .reset(reset),
    .tick(osc_tick)
  );

  // edge detector runs in sleep too, so a step held high over wake is not a step
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      step_prev_reg <= 1'b0;
    end else begin
      step_prev_reg <= step_in;
    end
  end

  // enable does not gate this, only sleep does
  // edges in sleep are dropped
  assign step_rise = step_in && !step_prev_reg && sleep_n;

  // next position: direction and resolution are read only here, at the edge
  always_comb begin
    // selects as on the pins
    res_sel = {microstep_select_b, microstep_select_a};
    share_sel = {fast_decay_share_sel_b, fast_decay_share_sel_a};
    step_size = STEP_TBL[res_sel];
    // wraps at one turn
    if (dir_ccw) begin
      pos_next = pos_reg - step_size;
    end else begin
      pos_next = pos_reg + step_size;
    end

    // phase 2 leads a quarter
    pos2_next = pos_next + 6'h10;
    level1_next = sine_level(pos_next);
    level2_next = sine_level(pos2_next);
    // zero share keeps the bridge in slow decay, so mixed adds nothing then
    falling_decay = STP_DECAY_MIXED;
  end

  // translator position and latched selects
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pos_reg <= `STP_HOME_POS;
      res_reg <= 2'b00;
      share_reg <= 2'b00;
    // home, keep resolution
    end else if (!sleep_n) begin
      pos_reg <= `STP_HOME_POS;
    // selects read only here
    end else if (step_rise) begin
      pos_reg <= pos_next;
      res_reg <= res_sel;
      share_reg <= share_sel;
    end
  end

  // dac levels and polarities follow the position at each step
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      level1_reg <= `STP_HOME_LEVEL;
      level2_reg <= `STP_HOME_LEVEL;
      pos1_reg <= 1'b1;
      pos2_reg <= 1'b1;
    // wake starts from home
    end else if (!sleep_n) begin
      level1_reg <= `STP_HOME_LEVEL;
      level2_reg <= `STP_HOME_LEVEL;
      pos1_reg <= 1'b1;
      pos2_reg <= 1'b1;
    // both phases, one edge
    end else if (step_rise) begin
      level1_reg <= level1_next;
      level2_reg <= level2_next;
      pos1_reg <= sine_positive(pos_next);
      pos2_reg <= sine_positive(pos2_next);
    end
  end

  // decay per bridge from the direction of its level change
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      decay1_reg <= STP_DECAY_MIXED;
      decay2_reg <= STP_DECAY_MIXED;
    // sleep acts as reset
    end else if (!sleep_n) begin
      decay1_reg <= STP_DECAY_MIXED;
      decay2_reg <= STP_DECAY_MIXED;
    end else if (step_rise) begin
      // magnitude compare
      decay1_reg <= (level1_next >= level1_reg) ? STP_DECAY_SLOW : falling_decay;
      decay2_reg <= (level2_next >= level2_reg) ? STP_DECAY_SLOW : falling_decay;
    end
  end

  // sleep, disable and undervoltage all kill the gates; sequencing carries on except in sleep
  // acts every clock
  assign gates_off = outputs_disable || gate_supply_rail_low || !sleep_n;

  // phase 1 link
  // trips sampled on ticks
  assign ph1.level = level1_reg;
  assign ph1.positive = pos1_reg;
  assign ph1.decay = decay1_reg;
  assign ph1.fast_ticks = FAST_TBL[share_reg];
  assign ph1.trip = trip_1;
  assign ph1.inhibit = gates_off;
  assign ph1.sleep = !sleep_n;
  assign ph1.tick = osc_tick;

  // phase 2 link
  // same share code
  assign ph2.level = level2_reg;
  assign ph2.positive = pos2_reg;
  assign ph2.decay = decay2_reg;
  assign ph2.fast_ticks = FAST_TBL[share_reg];
  assign ph2.trip = trip_2;
  assign ph2.inhibit = gates_off;
  assign ph2.sleep = !sleep_n;
  assign ph2.tick = osc_tick;

  // two regulators with no shared state beyond the oscillator
  stp_bridge u_bridge1 (
    .clock(clock),
    .reset(reset),
    .ph(ph1.bridge)
  );

  // second bridge
  stp_bridge u_bridge2 (
    .clock(clock),
    .reset(reset),
    .ph(ph2.bridge)
  );

  // gate pins come straight from the bridge registers
  assign high_side_gate_out = {ph2.high_gate, ph1.high_gate};
  assign low_side_gate_out = {ph2.low_gate, ph1.low_gate};

  // translator state
  assign phase1_dac_level = level1_reg;
  assign phase2_dac_level = level2_reg;
  assign phase1_positive = pos1_reg;
  assign phase2_positive = pos2_reg;
  assign phase1_decay = decay1_reg;
  assign phase2_decay = decay2_reg;
  assign resolution_latched = res_reg;

  // one clock domain here
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // cw edge adds the step
  chk_cw_advance: assert property (step_rise && !dir_ccw
    |=> pos_reg == 6'($past(pos_reg) + STEP_TBL[$past(res_sel)]))
    else $error("clockwise step did not advance by the increment");

  // ccw edge subtracts it
  chk_ccw_retreat: assert property (step_rise && dir_ccw
    |=> pos_reg == 6'($past(pos_reg) - STEP_TBL[$past(res_sel)]))
    else $error("counterclockwise step did not retreat by the increment");

  // no edge, no movement
  chk_select_hold: assert property (!step_rise && sleep_n && $past(sleep_n)
    |=> $stable(pos_reg) && $stable(res_reg))
    else $error("position or resolution moved without a step edge");

  // sleep reloads home
  chk_home_load: assert property (!sleep_n |=> pos_reg == `STP_HOME_POS &&
    decay1_reg == STP_DECAY_MIXED && decay2_reg == STP_DECAY_MIXED)
    else $error("sleep did not return to home with mixed decay");

  // levels follow position
  chk_sine_track: assert property (sleep_n && $past(sleep_n) |-> level1_reg == sine_level(pos_reg) &&
    level2_reg == sine_level(6'(pos_reg + 6'h10)))
    else $error("dac levels do not match the position");

  // rising level: slow
  chk_slow_decay: assert property (step_rise && level1_next >= level1_reg
    |=> decay1_reg == STP_DECAY_SLOW)
    else $error("rising phase 1 level not in slow decay");

  // falling level: mixed
  chk_mixed_decay: assert property (step_rise && level2_next < level2_reg
    |=> decay2_reg == STP_DECAY_MIXED ##0 ph2.fast_ticks == FAST_TBL[$past(share_sel)])
    else $error("falling phase 2 level not in selected mixed decay");

  // disable kills gates
  chk_disable_off: assert property (outputs_disable |=> high_side_gate_out == 4'h0 &&
    low_side_gate_out == 4'h0)
    else $error("gates on while disabled");

  // undervoltage kills gates
  chk_uv_off: assert property (gate_supply_rail_low [*2] |-> high_side_gate_out == 4'h0 &&
    low_side_gate_out == 4'h0)
    else $error("gates on during undervoltage");

  // stepping runs when disabled
  chk_run_disabled: assert property (outputs_disable && step_rise
    |=> pos_reg != $past(pos_reg))
    else $error("translator stopped while disabled");

  // main scenarios
  cov_sixteenth: cover property (step_rise && res_sel == 2'b11);
  cov_ccw_step: cover property (step_rise && dir_ccw);
  cov_mixed_pick: cover property (step_rise && level1_next < level1_reg);
  cov_wake_home: cover property (!sleep_n ##1 sleep_n);
endmodule // stp_top
`default_nettype wire

//--- test/stp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side: step pulses with sense and resolution, held between steps
module stp_host_model #(
  parameter int WAKE_CYCLES = 25000 // 1 ms of 40 ns clocks
) (
  input wire logic clock, // system clock
  input wire logic reset, // async, active high
  input wire logic sleep_n, // sleep line as the bench drives it
  output logic step_in, // step pulse
  output logic dir_ccw, // rotation sense
  output logic microstep_select_a, // resolution select a
  output logic microstep_select_b // resolution select b
);
  int awake_cnt; // clocks since leaving sleep, saturating

  // a device reset is not a sleep, so it starts out awake
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      awake_cnt <= WAKE_CYCLES;
    end else if (!sleep_n) begin
      awake_cnt <= 0;
    end else if (awake_cnt < WAKE_CYCLES) begin
      awake_cnt <= awake_cnt + 1;
    end
  end

  // quiet lines at time zero
  initial begin
    step_in = 1'b0;
    dir_ccw = 1'b0;
    {microstep_select_b, microstep_select_a} = 2'h0;
  end

  // change sense and selects between steps, no edge on step
  task automatic preset(input logic dir, input logic [1:0] code);
    @(posedge clock);
    #1;
    dir_ccw = dir;
    {microstep_select_b, microstep_select_a} = code;
  endtask

  // one step; the regulator needs time to settle after a wake
  task automatic do_step(input logic dir, input logic [1:0] code);
    while (awake_cnt < WAKE_CYCLES) @(posedge clock);
    preset(dir, code);
    step_in = 1'b1;
    @(posedge clock);
    #1;
    step_in = 1'b0;
  endtask
endmodule // stp_host_model
`default_nettype wire

//--- test/stp_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
// random steps against a sine model, plus regulator timing
module stp_top_bench;
  import stp_pkg::*;
  localparam int OSC = 6; // clocks per oscillator tick
  localparam int LIMIT = 40000; // one wake wait plus traffic
  logic clock = 1'b0; // 25 MHz
  logic reset = 1'b1; // held 20 clocks
  logic sleep_n = 1'b1; // awake
  logic [1:0] share = 2'h0; // fast share code {b,a}
  logic outputs_disable = 1'b0; // gates allowed
  logic rail_low = 1'b0; // supply good
  logic trip_1 = 1'b0; // comparators idle
  logic trip_2 = 1'b0;
  logic step_in, dir_ccw, ms_a, ms_b; // from the host model
  logic [3:0] high_g, low_g; // gate drives
  stp_level_t lvl1, lvl2; // dac set points
  logic pos1, pos2; // polarities
  stp_decay_t dec1, dec2; // decay modes
  logic [1:0] res_l; // latched resolution
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] seed = 32'he2c2;
  logic [5:0] exp_pos; // model position
  stp_level_t prev1, prev2; // last levels, for decay choice
  stp_decay_t exp_d1, exp_d2;
  logic [1:0] exp_res;
  logic [5:0] inc [0:3] = '{6'h10, 6'h08, 6'h04, 6'h01};

  always #20 clock = ~clock;

  stp_host_model host_u (.clock(clock), .reset(reset), .sleep_n(sleep_n), .step_in(step_in), .dir_ccw(dir_ccw),
    .microstep_select_a(ms_a), .microstep_select_b(ms_b));

  stp_top #(.OSC_DIV(OSC)) dut_u (.clock(clock), .reset(reset), .sleep_n(sleep_n), .step_in(step_in),
    .dir_ccw(dir_ccw), .microstep_select_a(ms_a), .microstep_select_b(ms_b), .fast_decay_share_sel_a(share[0]),
    .fast_decay_share_sel_b(share[1]), .outputs_disable(outputs_disable), .gate_supply_rail_low(rail_low),
    .trip_1(trip_1), .trip_2(trip_2), .high_side_gate_out(high_g), .low_side_gate_out(low_g),
    .phase1_dac_level(lvl1), .phase2_dac_level(lvl2), .phase1_positive(pos1), .phase2_positive(pos2),
    .phase1_decay(dec1), .phase2_decay(dec2), .resolution_latched(res_l));

  // quarter wave in 1/64 of full scale, mirrored over each half turn
  function automatic stp_level_t sine_level(input logic [5:0] p);
    logic [6:0] tbl [0:16];
    logic [5:0] q;
    tbl = '{7'h00, 7'h06, 7'h0c, 7'h13, 7'h18, 7'h1e, 7'h24, 7'h29, 7'h2d, 7'h31, 7'h35, 7'h38, 7'h3b,
            7'h3d, 7'h3f, 7'h40, 7'h40};
    q = (p[4:0] <= 5'h10) ? {1'b0, p[4:0]} : 6'h20 - {1'b0, p[4:0]};
    return tbl[q];
  endfunction

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // a hang counts against the run
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic cmp_lvl(input string what, input stp_level_t exp, input stp_level_t got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bits(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // step n edges, inputs land 1 ns after the last one
  task automatic clocks(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // home state; resolution only clears on a true reset
  task automatic home(input logic with_res);
    exp_pos = 6'h08;
    prev1 = 7'h2d;
    prev2 = 7'h2d;
    exp_d1 = STP_DECAY_MIXED;
    exp_d2 = STP_DECAY_MIXED;
    if (with_res) exp_res = 2'h0;
  endtask

  task automatic check_state();
    logic [5:0] p2;
    p2 = exp_pos + 6'h10;
    cmp_lvl("phase1 level", sine_level(exp_pos), lvl1);
    cmp_lvl("phase2 level", sine_level(p2), lvl2);
    cmp_bits("polarity", {2'h0, ~exp_pos[5], ~p2[5]}, {2'h0, pos1, pos2});
    cmp_bits("decay", {2'h0, exp_d1, exp_d2}, {2'h0, dec1, dec2});
    cmp_bits("resolution", {2'h0, exp_res}, {2'h0, res_l});
  endtask

  // rising or equal level keeps slow decay, a falling one goes mixed
  task automatic step_and_check(input logic dir, input logic [1:0] code);
    stp_level_t n1;
    stp_level_t n2;
    host_u.do_step(dir, code);
    exp_pos = dir ? exp_pos - inc[code] : exp_pos + inc[code];
    n1 = sine_level(exp_pos);
    n2 = sine_level(exp_pos + 6'h10);
    exp_d1 = (n1 >= prev1) ? STP_DECAY_SLOW : STP_DECAY_MIXED;
    exp_d2 = (n2 >= prev2) ? STP_DECAY_SLOW : STP_DECAY_MIXED;
    prev1 = n1;
    prev2 = n2;
    exp_res = code;
    check_state();
  endtask

  // wait on gate 1a, high or low side, bounded
  task automatic wait_gate(input logic low_side, input logic val, output int at);
    int n;
    n = 0;
    while (((low_side ? low_g[0] : high_g[0]) !== val) && n < 2000) begin
      clocks(1);
      n++;
    end
    at = cycles;
  endtask

  initial begin
    int t0;
    int t1;
    int t2;
    int t3;
    clocks(20);
    reset = 1'b0;
    home(1'b1);
    check_state();
    clocks(40 * OSC);
    cmp_bits("drive high", 4'h5, high_g);
    cmp_bits("drive low", 4'ha, low_g);
    step_and_check(1'b0, 2'h0);
    clocks(40 * OSC);
    trip_1 = 1'b1;
    wait_gate(1'b0, 1'b0, t0);
    wait_gate(1'b1, 1'b1, t1);
    trip_1 = 1'b0;
    cmp_bits("crossover gap", 4'h1, 4'((t1 - t0 >= 3 * OSC) && (t1 - t0 <= 4 * OSC)));
    cmp_bits("phase2 gates", 4'h9, {high_g[3:2], low_g[3:2]});
    wait_gate(1'b0, 1'b1, t2);
    cmp_bits("off interval", 4'h1, 4'((t2 - t0 >= 87 * OSC) && (t2 - t0 <= 93 * OSC)));
    trip_1 = 1'b1;
    wait_gate(1'b0, 1'b0, t3);
    trip_1 = 1'b0;
    cmp_bits("mask interval", 4'h1, 4'((t3 - t2 >= 2 * OSC) && (t3 - t2 <= 8 * OSC)));
    outputs_disable = 1'b1;
    clocks(1);
    cmp_bits("disabled gates", 4'h0, high_g | low_g);
    step_and_check(1'b1, 2'h1);
    outputs_disable = 1'b0;
    rail_low = 1'b1;
    clocks(1);
    cmp_bits("undervoltage gates", 4'h0, high_g | low_g);
    rail_low = 1'b0;
    sleep_n = 1'b0;
    clocks(3);
    cmp_bits("sleep gates", 4'h0, high_g | low_g);
    sleep_n = 1'b1;
    home(1'b0);
    check_state();
    host_u.preset(1'b1, 2'h3);
    clocks(5);
    check_state();
    for (int c = 0; c < 8; c++) step_and_check(c[2], c[1:0]);
    for (int i = 0; i < 150; i++) begin
      seed = xorshift(seed);
      share = seed[5:4];
      trip_2 = seed[6];
      step_and_check(seed[0], seed[2:1]);
    end
    complete_run();
  end
endmodule // stp_top_bench
`default_nettype wire
